// >>> verilog/spr_pkg.sv
// shared constants for the status pin router and receiver fill control
package spr_pkg;

    // register byte addresses on the control port
    localparam logic [7:0] SPR_ADDR_SEL_A = 8'h26;
    localparam logic [7:0] SPR_ADDR_SEL_B = 8'h27;
    localparam logic [7:0] SPR_ADDR_SEL_C = 8'h28;
    localparam logic [7:0] SPR_ADDR_SEL_D = 8'h29;
    localparam logic [7:0] SPR_ADDR_SEL_E = 8'h2A;

    // field positions inside a select register
    localparam int SPR_LO_FIELD_POS = 0;
    localparam int SPR_HI_FIELD_POS = 4;
    localparam int SPR_CTRL_BIT_POS = 8;

    // values after reset
    localparam logic [8:0] SPR_RST_SEL_A = 9'h010;
    localparam logic [8:0] SPR_RST_SEL_B = 9'h032;
    localparam logic [8:0] SPR_RST_SEL_C = 9'h054;
    localparam logic [8:0] SPR_RST_SEL_D = 9'h076;
    localparam logic [8:0] SPR_RST_SEL_E = 9'h098;

    // writable bits; bit 8 of registers c, d and e reads as zero
    localparam logic [8:0] SPR_MASK_CTRL = 9'h1FF;
    localparam logic [8:0] SPR_MASK_PLAIN = 9'h0FF;

    // pin source codes
    localparam logic [3:0] SPR_SRC_INTR_N = 4'h0;
    localparam logic [3:0] SPR_SRC_VALID = 4'h1;
    localparam logic [3:0] SPR_SRC_USER = 4'h2;
    localparam logic [3:0] SPR_SRC_CHSTAT = 4'h3;
    localparam logic [3:0] SPR_SRC_PARITY = 4'h4;
    localparam logic [3:0] SPR_SRC_SFRM = 4'h5;
    localparam logic [3:0] SPR_SRC_BLOCK = 4'h6;
    localparam logic [3:0] SPR_SRC_UNLOCK = 4'h7;
    localparam logic [3:0] SPR_SRC_CSUPD = 4'h8;
    localparam logic [3:0] SPR_SRC_RATE = 4'h9;
    localparam logic [3:0] SPR_SRC_ZERO = 4'hA;
    localparam logic [3:0] SPR_SRC_NONAUD = 4'hB;
    localparam logic [3:0] SPR_SRC_COPY = 4'hC;
    localparam logic [3:0] SPR_SRC_EMPH = 4'hD;
    localparam logic [3:0] SPR_SRC_IN_CMOS = 4'hE;
    localparam logic [3:0] SPR_SRC_IN_COMP = 4'hF;

    // routed pins two..nine, of which three..five may become inputs
    localparam int SPR_NUM_PINS = 8;
    localparam int SPR_NUM_BIDIR = 3;
    localparam int SPR_FIRST_BIDIR = 1;
    localparam int SPR_SYNC_STAGES = 2;

endpackage : spr_pkg

// >>> verilog/spr_rx_fill.sv
// receiver sample handling for corrupt or invalid input data
`timescale 1ns/1ns
module spr_rx_fill
    import spr_pkg::*;
#(
    parameter int DATA_W = 24
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [DATA_W-1:0] sample_in,
    input wire logic sample_stb,
    input wire logic sample_corrupt,
    input wire logic sample_invalid,
    input wire logic bad_data_fill_select,
    input wire logic validity_override,
    output logic [DATA_W-1:0] sample_out,
    output logic sample_out_stb
);

    logic [DATA_W-1:0] last_good;
    logic [DATA_W-1:0] next_last_good;
    logic [DATA_W-1:0] next_sample_out;
    logic next_sample_out_stb;
    logic sample_bad;

    // invalid flag ignored when the override is set
    assign sample_bad = sample_corrupt |
        (sample_invalid & ~validity_override);

    ////////////////////////////////////////////////////////////////////////
    // next sample and last good sample
    always_comb begin
        next_last_good = last_good;
        next_sample_out = sample_out;
        next_sample_out_stb = sample_stb;
        if (sample_stb) begin
            if (!sample_bad) begin
                next_last_good = sample_in;
                next_sample_out = sample_in;
            end else if (bad_data_fill_select) begin
                next_sample_out = '0;
            end else begin
                next_sample_out = last_good;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            last_good <= '0;
            sample_out <= '0;
            sample_out_stb <= 1'b0;
        end else begin
            last_good <= next_last_good;
            sample_out <= next_sample_out;
            sample_out_stb <= next_sample_out_stb;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_hold_last_good: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        sample_stb && sample_bad && !bad_data_fill_select
        |=> sample_out == $past(last_good) && sample_out_stb)
        else $error("bad sample did not repeat last good one");

    a_fill_zero_out: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        sample_stb && sample_bad && bad_data_fill_select
        |=> sample_out == '0)
        else $error("bad sample not replaced by zero");

    a_override_invalid: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        sample_stb && sample_invalid && !sample_corrupt && validity_override
        |=> sample_out == $past(sample_in))
        else $error("invalid flag not ignored under override");

    c_fill_zero: cover property (@(posedge ref_clk) disable iff (!rst_b)
        sample_stb && sample_bad && bad_data_fill_select);

endmodule : spr_rx_fill

// >>> verilog/spr_pin_router.sv
// receiver status pin router with select registers and fill control
//
// Function
// - each four-bit select field of pins two to nine puts one of fourteen status signals on its pin, code 0 the interrupt through code 13 emphasis.
// - after reset pins two to nine select codes one to eight in order.
// - code 14 releases the pin and uses it as a receiver input with a logic-level buffer.
// - code 15 uses the pin as a receiver input with a comparator buffer for AC-coupled signals.
// - the two input codes act only on pins three, four and five and software keeps them off other pins.
// - bit 8 of the first select register picks the bad-data treatment and resets to zero.
// - with that bit clear the receiver output holds the last valid sample while data is bad.
// - with that bit set bad data is replaced by all-zero samples.
// - bit 8 of the second select register resets to zero and when set makes the invalid flag be ignored.
`timescale 1ns/1ns
module spr_pin_router
    import spr_pkg::*;
#(
    parameter int DATA_W = 24
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [8:0] reg_wdata,
    output logic [8:0] reg_rdata,
    input wire logic interrupt_out_n,
    input wire logic validity_flag,
    input wire logic user_bit,
    input wire logic channel_status_bit,
    input wire logic parity_bit,
    input wire logic subframe_clock_out,
    input wire logic block_start_marker,
    input wire logic lock_loss,
    input wire logic channel_status_update,
    input wire logic rate_high_flag,
    input wire logic zero_detect_flag,
    input wire logic compressed_payload_flag,
    input wire logic copy_permit_flag,
    input wire logic emphasis_indicator,
    input wire logic [SPR_NUM_BIDIR-1:0] pin_in,
    output logic [SPR_NUM_PINS-1:0] pin_out,
    output logic [SPR_NUM_PINS-1:0] pin_oe_n,
    output logic [SPR_NUM_BIDIR-1:0] rx_pin_data,
    output logic [SPR_NUM_BIDIR-1:0] rx_pin_active,
    output logic [SPR_NUM_BIDIR-1:0] rx_pin_comparator,
    input wire logic [DATA_W-1:0] rx_sample,
    input wire logic rx_sample_stb,
    input wire logic rx_corrupt,
    input wire logic rx_invalid,
    output logic [DATA_W-1:0] audio_sample,
    output logic audio_stb
);

    logic [8:0] sel_a;
    logic [8:0] sel_b;
    logic [8:0] sel_c;
    logic [8:0] sel_d;
    logic [8:0] sel_e;
    logic [8:0] next_sel_a;
    logic [8:0] next_sel_b;
    logic [8:0] next_sel_c;
    logic [8:0] next_sel_d;
    logic [8:0] next_sel_e;
    logic [8:0] next_reg_rdata;
    logic [3:0] pin_sel [SPR_NUM_PINS];
    logic [15:0] status_vec;
    logic [SPR_NUM_PINS-1:0] next_pin_out;
    logic [SPR_NUM_PINS-1:0] next_pin_oe_n;
    logic [SPR_NUM_BIDIR-1:0] pin_in_meta;
    logic [SPR_NUM_BIDIR-1:0] pin_in_sync;
    logic [SPR_NUM_BIDIR-1:0] next_rx_pin_data;
    logic [SPR_NUM_BIDIR-1:0] next_rx_pin_active;
    logic [SPR_NUM_BIDIR-1:0] next_rx_pin_comparator;
    logic bad_data_fill_select;
    logic validity_override;

    ////////////////////////////////////////////////////////////////////////
    // select registers
    always_comb begin
        next_sel_a = sel_a;
        next_sel_b = sel_b;
        next_sel_c = sel_c;
        next_sel_d = sel_d;
        next_sel_e = sel_e;
        if (reg_wr) begin
            unique case (reg_addr)
                SPR_ADDR_SEL_A: next_sel_a = reg_wdata & SPR_MASK_CTRL;
                SPR_ADDR_SEL_B: next_sel_b = reg_wdata & SPR_MASK_CTRL;
                SPR_ADDR_SEL_C: next_sel_c = reg_wdata & SPR_MASK_PLAIN;
                SPR_ADDR_SEL_D: next_sel_d = reg_wdata & SPR_MASK_PLAIN;
                SPR_ADDR_SEL_E: next_sel_e = reg_wdata & SPR_MASK_PLAIN;
                default: next_sel_a = sel_a; // unmapped writes dropped
            endcase
        end
    end

    // read data is registered; unmapped addresses read zero
    always_comb begin
        unique case (reg_addr)
            SPR_ADDR_SEL_A: next_reg_rdata = sel_a;
            SPR_ADDR_SEL_B: next_reg_rdata = sel_b;
            SPR_ADDR_SEL_C: next_reg_rdata = sel_c;
            SPR_ADDR_SEL_D: next_reg_rdata = sel_d;
            SPR_ADDR_SEL_E: next_reg_rdata = sel_e;
            default: next_reg_rdata = '0;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sel_a <= SPR_RST_SEL_A;
            sel_b <= SPR_RST_SEL_B;
            sel_c <= SPR_RST_SEL_C;
            sel_d <= SPR_RST_SEL_D;
            sel_e <= SPR_RST_SEL_E;
            reg_rdata <= '0;
        end else begin
            sel_a <= next_sel_a;
            sel_b <= next_sel_b;
            sel_c <= next_sel_c;
            sel_d <= next_sel_d;
            sel_e <= next_sel_e;
            reg_rdata <= next_reg_rdata;
        end
    end

    // pins one and ten keep their fields for readback only; nothing here
    // routes them, so software may park any code there
    // field map: pin two in a[7:4], then low/high nibbles onward
    assign pin_sel[0] = sel_a[SPR_HI_FIELD_POS +: 4];
    assign pin_sel[1] = sel_b[SPR_LO_FIELD_POS +: 4];
    assign pin_sel[2] = sel_b[SPR_HI_FIELD_POS +: 4];
    assign pin_sel[3] = sel_c[SPR_LO_FIELD_POS +: 4];
    assign pin_sel[4] = sel_c[SPR_HI_FIELD_POS +: 4];
    assign pin_sel[5] = sel_d[SPR_LO_FIELD_POS +: 4];
    assign pin_sel[6] = sel_d[SPR_HI_FIELD_POS +: 4];
    assign pin_sel[7] = sel_e[SPR_LO_FIELD_POS +: 4];
    assign bad_data_fill_select = sel_a[SPR_CTRL_BIT_POS];
    assign validity_override = sel_b[SPR_CTRL_BIT_POS];

    ////////////////////////////////////////////////////////////////////////
    // status sources by code; input codes index zeros, so a pin
    // that cannot become an input just drives low
    assign status_vec = {2'b00, emphasis_indicator, copy_permit_flag,
        compressed_payload_flag, zero_detect_flag, rate_high_flag,
        channel_status_update, lock_loss, block_start_marker,
        subframe_clock_out, parity_bit, channel_status_bit, user_bit,
        validity_flag, interrupt_out_n};

    // per-pin output mux, registered to keep pins glitch free
    for (genvar i = 0; i < SPR_NUM_PINS; i++) begin : g_pin
        localparam bit BIDIR = (i >= SPR_FIRST_BIDIR) &&
            (i < SPR_FIRST_BIDIR + SPR_NUM_BIDIR);
        always_comb begin
            next_pin_out[i] = status_vec[pin_sel[i]];
            next_pin_oe_n[i] = 1'b0;
            if (BIDIR && pin_sel[i] >= SPR_SRC_IN_CMOS) begin
                next_pin_out[i] = 1'b0;
                next_pin_oe_n[i] = 1'b1;
            end
        end
        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                pin_out[i] <= 1'b0;
                pin_oe_n[i] <= 1'b0;
            end else begin
                pin_out[i] <= next_pin_out[i];
                pin_oe_n[i] <= next_pin_oe_n[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // input side of pins three to five
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pin_in_meta <= '0;
            pin_in_sync <= '0;
        end else begin
            pin_in_meta <= pin_in;
            pin_in_sync <= pin_in_meta;
        end
    end

    // buffer type flag tells the receiver which input circuit is meant
    for (genvar j = 0; j < SPR_NUM_BIDIR; j++) begin : g_rx_in
        always_comb begin
            next_rx_pin_active[j] =
                pin_sel[j+SPR_FIRST_BIDIR] >= SPR_SRC_IN_CMOS;
            next_rx_pin_comparator[j] =
                pin_sel[j+SPR_FIRST_BIDIR] == SPR_SRC_IN_COMP;
            next_rx_pin_data[j] = pin_in_sync[j] & next_rx_pin_active[j];
        end
        always_ff @(posedge ref_clk) begin
            if (!rst_b) begin
                rx_pin_active[j] <= 1'b0;
                rx_pin_comparator[j] <= 1'b0;
                rx_pin_data[j] <= 1'b0;
            end else begin
                rx_pin_active[j] <= next_rx_pin_active[j];
                rx_pin_comparator[j] <= next_rx_pin_comparator[j];
                rx_pin_data[j] <= next_rx_pin_data[j];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver data handling
    spr_rx_fill #(
        .DATA_W(DATA_W)
    ) u_rx_fill (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .sample_in(rx_sample),
        .sample_stb(rx_sample_stb),
        .sample_corrupt(rx_corrupt),
        .sample_invalid(rx_invalid),
        .bad_data_fill_select(bad_data_fill_select),
        .validity_override(validity_override),
        .sample_out(audio_sample),
        .sample_out_stb(audio_stb)
    );

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_reset_codes_seq: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        $rose(rst_b) |-> pin_sel[0] == 4'h1 && pin_sel[3] == 4'h4 &&
            pin_sel[7] == 4'h8 && !bad_data_fill_select &&
            !validity_override)
        else $error("select fields wrong after reset");

    a_mux_intr_pin: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[0] == SPR_SRC_INTR_N
        |=> pin_out[0] == $past(interrupt_out_n) && !pin_oe_n[0])
        else $error("pin two does not follow interrupt");

    a_mux_emph_pin: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[6] == SPR_SRC_EMPH
        |=> pin_out[6] == $past(emphasis_indicator))
        else $error("pin eight does not follow emphasis");

    // pin five resets to parity, so this one is live from the start
    a_mux_parity_pin: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[3] == SPR_SRC_PARITY
        |=> pin_out[3] == $past(parity_bit) && !pin_oe_n[3])
        else $error("pin five does not follow parity");

    a_cmos_input_release: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[1] == SPR_SRC_IN_CMOS [*2]
        |=> pin_oe_n[1] && rx_pin_active[0] && !rx_pin_comparator[0])
        else $error("pin three not released as logic input");

    a_pin5_cmos_input: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[3] == SPR_SRC_IN_CMOS
        |=> pin_oe_n[3] && rx_pin_active[2] && !rx_pin_comparator[2])
        else $error("pin five not released as logic input");

    a_comp_input_mode: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[2] == SPR_SRC_IN_COMP
        |=> pin_oe_n[2] && rx_pin_comparator[1])
        else $error("pin four not a comparator input");

    a_bad_code_low: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        pin_sel[5] >= SPR_SRC_IN_CMOS
        |=> !pin_out[5] && !pin_oe_n[5])
        else $error("non-input pin not driven low on input code");

    // a stray release of an output-only pin would leave it floating
    a_oe_bidir_only: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        !pin_oe_n[0] &&
            pin_oe_n[SPR_NUM_PINS-1:SPR_FIRST_BIDIR+SPR_NUM_BIDIR] == '0)
        else $error("pin released outside three to five");

    // a pin in output use must hand nothing to the receiver
    a_rx_data_gated: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        (rx_pin_data & ~rx_pin_active) == '0)
        else $error("receiver fed from a pin not in input use");

    a_write_latency_two: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        reg_wr && reg_addr == SPR_ADDR_SEL_C &&
            reg_wdata[SPR_HI_FIELD_POS +: 4] == SPR_SRC_SFRM
        |=> ##1 pin_out[4] == $past(subframe_clock_out))
        else $error("pin six late after select write");

    a_fill_bit_store: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        reg_wr && reg_addr == SPR_ADDR_SEL_A
        |=> bad_data_fill_select == $past(reg_wdata[SPR_CTRL_BIT_POS])
            ##1 reg_addr != SPR_ADDR_SEL_A ||
            reg_rdata[SPR_CTRL_BIT_POS] == bad_data_fill_select)
        else $error("fill select bit not stored");

    a_override_store: assert property (@(posedge ref_clk)
        disable iff (!rst_b)
        reg_wr && reg_addr == SPR_ADDR_SEL_B
        |=> validity_override == $past(reg_wdata[SPR_CTRL_BIT_POS]))
        else $error("validity override bit not stored");

    c_pin_to_input: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pin_sel[2] == SPR_SRC_IN_COMP ##1 pin_oe_n[2]);
    c_pin5_input: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pin_sel[3] == SPR_SRC_IN_CMOS ##1 rx_pin_active[2]);
    c_override_set: cover property (@(posedge ref_clk) disable iff (!rst_b)
        validity_override && rx_sample_stb && rx_invalid);
    c_pin_code_change: cover property (@(posedge ref_clk)
        disable iff (!rst_b)
        reg_wr && reg_addr == SPR_ADDR_SEL_D ##2 $changed(pin_out[5]));

endmodule : spr_pin_router

// >>> tb/spr_pin_partner.sv
// far-side logic model that shares the receiver input pins
`timescale 1ns/1ns
module spr_pin_partner
    import spr_pkg::*;
(
    input wire logic [SPR_NUM_PINS-1:0] pin_out,
    input wire logic [SPR_NUM_PINS-1:0] pin_oe_n,
    input wire logic [SPR_NUM_BIDIR-1:0] drive,
    output logic [SPR_NUM_BIDIR-1:0] pin_in
);
    // pin level: device while it drives, far side once released
    always_comb begin
        for (int i = 0; i < SPR_NUM_BIDIR; i++) begin
            pin_in[i] = pin_oe_n[i+SPR_FIRST_BIDIR] ? drive[i]
                : pin_out[i+SPR_FIRST_BIDIR];
        end
    end
endmodule : spr_pin_partner

// >>> tb/tb_top.sv
// self-checking bench for the status pin router
`timescale 1ns/1ns
module tb_top
    import spr_pkg::*;
;
    logic ref_clk, rst_b, reg_wr, rx_sample_stb, rx_corrupt, rx_invalid;
    logic audio_stb;
    logic [7:0] reg_addr, pin_out, pin_oe_n;
    logic [8:0] reg_wdata, reg_rdata;
    logic [13:0] src;
    logic [2:0] pin_in, drive, rx_pin_data, rx_pin_active, rx_pin_comparator;
    logic [23:0] rx_sample, audio_sample, last;
    logic [15:0] rng;
    int fails, checked;

    ////////////////////////////////////////////////////////////////////////
    spr_pin_router #(.DATA_W(24)) i_spr_pin_router (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .interrupt_out_n(src[0]), .validity_flag(src[1]),
        .user_bit(src[2]), .channel_status_bit(src[3]),
        .parity_bit(src[4]), .subframe_clock_out(src[5]),
        .block_start_marker(src[6]), .lock_loss(src[7]),
        .channel_status_update(src[8]), .rate_high_flag(src[9]),
        .zero_detect_flag(src[10]), .compressed_payload_flag(src[11]),
        .copy_permit_flag(src[12]), .emphasis_indicator(src[13]),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .rx_pin_data(rx_pin_data), .rx_pin_active(rx_pin_active),
        .rx_pin_comparator(rx_pin_comparator), .rx_sample(rx_sample),
        .rx_sample_stb(rx_sample_stb), .rx_corrupt(rx_corrupt),
        .rx_invalid(rx_invalid), .audio_sample(audio_sample),
        .audio_stb(audio_stb)
    );
    spr_pin_partner i_spr_pin_partner (
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .drive(drive),
        .pin_in(pin_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // free-running core clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // input codes never show a status source on the pin
    function automatic logic pin_exp(input logic [3:0] c,
                                     input logic [13:0] s);
        return (c > 4'hD) ? 1'b0 : s[c];
    endfunction : pin_exp

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [8:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data is registered, so allow two edges before looking
    task automatic rd_chk(input logic [7:0] a, input logic [8:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 chk(32'(reg_rdata), 32'(e));
    endtask : rd_chk

    task automatic wait2;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : wait2

    task automatic new_src;
        rng = lfsr(rng);
        @(posedge ref_clk);
        src <= rng[13:0];
    endtask : new_src

    task automatic pins(input logic [3:0] base, input logic [3:0] step);
        for (int k = 0; k < 8; k++) begin
            chk(32'(pin_out[k]),
                32'(pin_exp(4'(base + k * step), src)));
        end
    endtask : pins

    // one sample through the receiver; f and o mirror register bit 8
    task automatic smp(input logic c, input logic v, input logic f,
                       input logic o);
        logic [23:0] d, e;
        logic bad;
        rng = lfsr(rng);
        d = {rng[7:0], rng};
        bad = c | (v & ~o);
        e = bad ? (f ? 24'h00_0000 : last) : d;
        if (!bad) last = d;
        @(posedge ref_clk);
        rx_sample_stb <= 1'b1;
        rx_sample <= d;
        rx_corrupt <= c;
        rx_invalid <= v;
        @(posedge ref_clk);
        rx_sample_stb <= 1'b0;
        #1 chk(32'(audio_stb), 32'h0000_0001);
        chk(32'(audio_sample), 32'(e));
    endtask : smp

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the roughly 300 cycles of the tests
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        summarize();
    end

    initial begin
        rst_b = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 9'h000;
        src = 14'h0000;
        drive = 3'b000;
        rx_sample = 24'h00_0000;
        rx_sample_stb = 1'b0;
        rx_corrupt = 1'b0;
        rx_invalid = 1'b0;
        rng = 16'hBEE5;
        last = 24'h00_0000;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        // reset values: consecutive codes, control bits clear
        for (int i = 0; i < 5; i++) begin
            rd_chk(8'(SPR_ADDR_SEL_A + i), (i == 0) ? 9'h010
                : {1'b0, 4'(2 * i + 1), 4'(2 * i)});
        end
        rd_chk(8'h30, 9'h000);
        new_src();
        wait2();
        pins(4'h1, 4'h1);
        $display("test reset done");
        // every status code on every pin, both source levels
        for (int c = 0; c < 14; c++) begin
            wr(SPR_ADDR_SEL_A, {1'b0, 4'(c), 4'h0});
            for (int r = 1; r < 5; r++) begin
                wr(8'(SPR_ADDR_SEL_A + r), {1'b0, 4'(c), 4'(c)});
            end
            new_src();
            wait2();
            pins(4'(c), 4'h0);
            @(posedge ref_clk);
            src <= ~src;
            wait2();
            pins(4'(c), 4'h0);
        end
        $display("test codes done");
        // bit 8 is kept only in the first two registers
        wr(SPR_ADDR_SEL_C, 9'h1AB);
        rd_chk(SPR_ADDR_SEL_C, 9'h0AB);
        // pins 3, 5 logic in, pin 4 comparator, 2 and 6..8 misprogrammed
        wr(SPR_ADDR_SEL_B, 9'h0FE);
        wr(SPR_ADDR_SEL_A, 9'h0E0);
        wr(SPR_ADDR_SEL_C, 9'h0FE);
        wr(SPR_ADDR_SEL_D, 9'h0EF);
        for (int n = 0; n < 2; n++) begin
            @(posedge ref_clk);
            drive <= n ? 3'b110 : 3'b011;
            repeat (5) @(posedge ref_clk);
            #1 chk(32'(pin_oe_n), 32'h0000_000E);
            chk(32'(pin_out & 8'h7F), 32'h0000_0000);
            chk(32'(rx_pin_active), 32'h0000_0007);
            chk(32'(rx_pin_comparator), 32'h0000_0002);
            chk(32'(rx_pin_data), 32'(drive));
        end
        $display("test input pins done");
        // bad-data handling in all fill and override settings
        wr(SPR_ADDR_SEL_A, 9'h010);
        wr(SPR_ADDR_SEL_B, 9'h032);
        smp(1'b1, 1'b0, 1'b0, 1'b0);
        smp(1'b0, 1'b0, 1'b0, 1'b0);
        smp(1'b1, 1'b0, 1'b0, 1'b0);
        smp(1'b0, 1'b1, 1'b0, 1'b0);
        wr(SPR_ADDR_SEL_A, 9'h110);
        rd_chk(SPR_ADDR_SEL_A, 9'h110);
        smp(1'b1, 1'b0, 1'b1, 1'b0);
        smp(1'b0, 1'b1, 1'b1, 1'b0);
        wr(SPR_ADDR_SEL_B, 9'h132);
        smp(1'b0, 1'b1, 1'b1, 1'b1);
        smp(1'b1, 1'b1, 1'b1, 1'b1);
        wr(SPR_ADDR_SEL_A, 9'h010);
        smp(1'b0, 1'b1, 1'b0, 1'b1);
        $display("test fill done");
        summarize();
    end
endmodule : tb_top
